/* verilog/cfg_bank_pkg.sv */
// constants, encodings and states of the output protocol configuration bank
// What this block does
// - Bits 15:13 pick the output: 100 pulse-width, 010 SENT, 001 triggered.
// - Bit 12 low starts each pulse-width period rising, high starts it falling.
// - Bit 11 sets every SENT/triggered low phase to 5 or 3 unit times.
// - Bit 10 high adds two temperature nibbles to triggered frames.
// - Bit 9 low sends the rolling-counter nibble; high leaves it out.
// - Bit 8 high puts the rolling counter into the frame checksum.
// - Bit 7 low expects a 90 unit-time trigger; high accepts any length.
// - Bit 6 low gives secure SENT frames; high gives standard SENT.
// - Bit 5 low puts error code 4091 in data; high flags status only.
// - Bit 4 high appends a pause pulse after each SENT frame.
// - Bit 3 high carries a short serial message across frames.
// - Bits 2:0 give the unit time: 3, 2.5, 2.0, 1.5 or 1.0 us.
// - Address-source bit high takes link address from pins, else stored field.
// - The triggered protocol always uses the stored two-bit slave identifier.
// - Slave address bits 9:8 decode directly to identifiers 0 to 3.
// - Config checksum covers words 0x96 to 0xa2, then the upper byte of 0xa4.
// - Table checksum covers pages 0xb to 0xe, then the upper byte of 0xf0.
// - Customer identifier lives at 0xf2 to 0xfe; first 32 bits feed the message.
// - Working values are refreshed about every 25 microseconds.
// - Each protocol bit is ANDed with the lock word; locked ones do nothing.
package cfg_bank_pkg;
  localparam int CLK_NS = 20;
  localparam int UPDATE_NS = 25000;
  localparam int UPDATE_CYC = UPDATE_NS / CLK_NS;
  localparam logic [10:0] UPDATE_LAST = 11'(UPDATE_CYC - 1);
  // byte addresses of the words the bank looks at
  localparam logic [7:0] OFS_CFG_FIRST = 8'h96;
  localparam logic [7:0] OFS_LOCK = 8'h9a;
  localparam logic [7:0] OFS_PROTO = 8'ha2;
  localparam logic [7:0] OFS_CRCADR = 8'ha4;
  localparam logic [7:0] OFS_LUT_FIRST = 8'hb0;
  localparam logic [7:0] OFS_LUT_LAST = 8'hee;
  localparam logic [7:0] OFS_LUTCRC = 8'hf0;
  localparam logic [7:0] OFS_ID0 = 8'hf2;
  localparam logic [7:0] OFS_ID1 = 8'hf4;
  localparam logic [7:0] OFS_SCAN_LAST = 8'hf4;
  // output_protocol_select fields
  localparam int PS_MODE_HI = 15;
  localparam int PS_MODE_LO = 13;
  localparam int PS_EDGE = 12;
  localparam int PS_LOW = 11;
  localparam int PS_TEMP = 10;
  localparam int PS_CNT_OFF = 9;
  localparam int PS_CNT_CRC = 8;
  localparam int PS_TRIG = 7;
  localparam int PS_VARIANT = 6;
  localparam int PS_ERR = 5;
  localparam int PS_PAUSE = 4;
  localparam int PS_SSM = 3;
  localparam int PS_UT_HI = 2;
  // checksum_and_address_config fields
  localparam int CA_SRC = 10;
  localparam int CA_ID_HI = 9;
  localparam int CA_ID_LO = 8;
  localparam int CA_CRC_HI = 7;
  localparam logic [2:0] MODE_PWM = 3'h4;
  localparam logic [2:0] MODE_SENT = 3'h2;
  localparam logic [2:0] MODE_TRIG = 3'h1;
  // unit times
  localparam int UT0_NS = 3000;
  localparam int UT1_NS = 2500;
  localparam int UT2_NS = 2000;
  localparam int UT3_NS = 1500;
  localparam int UT4_NS = 1000;
  localparam logic [7:0] UT0_CYC = 8'((UT0_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] UT1_CYC = 8'((UT1_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] UT2_CYC = 8'((UT2_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] UT3_CYC = 8'((UT3_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] UT4_CYC = 8'((UT4_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] LOW_LONG_UT = 10'h005;
  localparam logic [9:0] LOW_SHORT_UT = 10'h003;
  localparam logic [13:0] TRIG_UT = 14'h005a;
  localparam logic [11:0] ERR_CODE = 12'hffb;
  localparam logic [7:0] CRC_INIT = 8'hff;
  localparam logic [15:0] WORD_RST = 16'h0000;
  typedef enum logic [1:0] {
    SC_IDLE = 2'b00,
    SC_RUN = 2'b01,
    SC_DRAIN = 2'b10,
    SC_PUB = 2'b11
  } scan_e;
endpackage

/* verilog/cfg_mem_if.sv */
// port between the bank logic and its word store
`timescale 1ns/1ps
interface cfg_mem_if #(parameter int AW = 7, parameter int DW = 16);
  logic we;
  logic re;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctl(output we, output re, output addr, output wdata, input rdata);
  modport mem(input we, input re, input addr, input wdata, output rdata);
endinterface

/* verilog/cfg_word_mem.sv */
// nonvolatile word store of the configuration bank, registered read
`timescale 1ns/1ps
module cfg_word_mem #(
  parameter int AW = 7,
  parameter int DW = 16
) (
  // clock
  input wire logic mclk,
  // access
  cfg_mem_if.mem m
);
  // no reset: contents model stored cells that survive reset
  logic [DW-1:0] cells [2**AW];

  always_ff @(posedge mclk) begin
    if (m.we) begin
      cells[m.addr] <= m.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (m.re) begin
      m.rdata <= cells[m.addr];
    end
  end
endmodule

/* verilog/output_protocol_config_bank.sv */
// output protocol configuration bank: word store, scan, checksums, decode
`timescale 1ns/1ps
module output_protocol_config_bank #(
  parameter bit PROTOCOL_SELECTABLE = 1'b1,
  parameter logic [2:0] FIXED_PROTOCOL = 3'h2,
  parameter logic [7:0] CRC_POLY = 8'h1d
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // word access from the configuration link
  input wire logic cfg_we,
  input wire logic cfg_re,
  input wire logic [7:0] cfg_addr,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata,
  output logic cfg_rvalid,
  // address strap pins
  input wire logic [1:0] addr_pins,
  // decoded protocol settings
  output logic [2:0] protocol_choice,
  output logic pwm_start_falling,
  output logic [9:0] low_phase_cycles,
  output logic temperature_nibbles_on,
  output logic counter_nibble_on,
  output logic counter_in_checksum,
  output logic trigger_length_variable,
  output logic [13:0] trigger_cycles,
  output logic frame_variant_select,
  output logic error_in_data,
  output logic [11:0] error_data_code,
  output logic pause_pulse_on,
  output logic slow_message_on,
  output logic [7:0] unit_time_cycles,
  // addressing and integrity
  output logic [1:0] link_address,
  output logic [1:0] triggered_slave_id,
  output logic cfg_crc_ok,
  output logic lut_crc_ok,
  output logic [31:0] slow_message_id,
  output logic working_refresh
);
  cfg_mem_if #(.AW(7), .DW(16)) mbus ();

  cfg_word_mem #(.AW(7), .DW(16)) u_mem (
    .mclk(mclk),
    .m(mbus.mem)
  );

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic logic [7:0] ut_cycles(input logic [2:0] code);
    logic [7:0] r;
    case (code)
      3'h0: r = cfg_bank_pkg::UT0_CYC;
      3'h1: r = cfg_bank_pkg::UT1_CYC;
      3'h2: r = cfg_bank_pkg::UT2_CYC;
      3'h3: r = cfg_bank_pkg::UT3_CYC;
      3'h4: r = cfg_bank_pkg::UT4_CYC;
      default: r = cfg_bank_pkg::UT0_CYC;
    endcase
    return r;
  endfunction

  cfg_bank_pkg::scan_e state_q;
  cfg_bank_pkg::scan_e state_d;
  logic [10:0] tick_cnt_q;
  logic [7:0] scan_addr_q;
  logic [7:0] tag_q;
  logic scan_rd_q;
  logic host_rd_q;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic [7:0] crc_c_q;
  logic [7:0] crc_l_q;
  logic [15:0] sh_lock_q;
  logic [15:0] sh_proto_q;
  logic [15:0] sh_crcadr_q;
  logic [15:0] sh_lutcrc_q;
  logic [15:0] sh_id0_q;
  logic [15:0] sh_id1_q;
  logic [15:0] proto_q;
  logic [15:0] crcadr_q;
  logic [7:0] ut_q;
  logic [9:0] low_q;
  logic [13:0] trig_q;
  logic [31:0] id_q;
  logic cfg_ok_q;
  logic lut_ok_q;
  logic pub_done_q;
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] link_addr_q;

  // update tick and scan control
  wire tick = (tick_cnt_q == 11'h000);
  wire host_busy = cfg_we | cfg_re;
  wire scan_issue = (state_q == cfg_bank_pkg::SC_RUN) & ~host_busy;
  wire scan_at_end = (scan_addr_q == cfg_bank_pkg::OFS_SCAN_LAST);
  wire pub = (state_q == cfg_bank_pkg::SC_PUB);

  // store port: host has priority, the scan waits out host cycles
  assign mbus.we = cfg_we;
  assign mbus.re = cfg_re | scan_issue;
  assign mbus.addr = host_busy ? cfg_addr[7:1] : scan_addr_q[7:1];
  assign mbus.wdata = cfg_wdata;

  // classify the word coming back from the scan
  wire [15:0] rd = mbus.rdata;
  wire in_cfg = scan_rd_q & (tag_q >= cfg_bank_pkg::OFS_CFG_FIRST) &
                (tag_q <= cfg_bank_pkg::OFS_PROTO);
  wire at_crcadr = scan_rd_q & (tag_q == cfg_bank_pkg::OFS_CRCADR);
  wire in_lut = scan_rd_q & (tag_q >= cfg_bank_pkg::OFS_LUT_FIRST) &
                (tag_q <= cfg_bank_pkg::OFS_LUT_LAST);
  wire at_lutcrc = scan_rd_q & (tag_q == cfg_bank_pkg::OFS_LUTCRC);
  wire [7:0] crc_c_word = crc8(crc8(crc_c_q, rd[15:8]), rd[7:0]);
  wire [7:0] crc_c_tail = crc8(crc_c_q, rd[15:8]);
  wire [7:0] crc_l_word = crc8(crc8(crc_l_q, rd[15:8]), rd[7:0]);
  wire [7:0] crc_l_tail = crc8(crc_l_q, rd[15:8]);

  // lock masking and fixed-protocol parts
  wire [15:0] masked = sh_proto_q & sh_lock_q;
  wire [2:0] mode_sel = PROTOCOL_SELECTABLE ?
                        masked[cfg_bank_pkg::PS_MODE_HI:cfg_bank_pkg::PS_MODE_LO] :
                        FIXED_PROTOCOL;
  wire [15:0] eff_proto = {mode_sel, masked[12:0]};
  wire [7:0] ut_n = ut_cycles(eff_proto[cfg_bank_pkg::PS_UT_HI:0]);
  wire [9:0] low_mul = eff_proto[cfg_bank_pkg::PS_LOW] ?
                       cfg_bank_pkg::LOW_SHORT_UT : cfg_bank_pkg::LOW_LONG_UT;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      cfg_bank_pkg::SC_IDLE: begin
        if (tick) begin
          state_d = cfg_bank_pkg::SC_RUN;
        end
      end
      cfg_bank_pkg::SC_RUN: begin
        if (scan_issue && scan_at_end) begin
          state_d = cfg_bank_pkg::SC_DRAIN;
        end
      end
      cfg_bank_pkg::SC_DRAIN: begin
        state_d = cfg_bank_pkg::SC_PUB;
      end
      cfg_bank_pkg::SC_PUB: begin
        state_d = cfg_bank_pkg::SC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= cfg_bank_pkg::SC_IDLE;
      tick_cnt_q <= 11'h000;
    end else begin
      state_q <= state_d;
      tick_cnt_q <= tick ? cfg_bank_pkg::UPDATE_LAST : tick_cnt_q - 11'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      scan_addr_q <= cfg_bank_pkg::OFS_CFG_FIRST;
      tag_q <= 8'h00;
      scan_rd_q <= 1'b0;
    end else begin
      scan_rd_q <= scan_issue;
      if (scan_issue) begin
        tag_q <= scan_addr_q;
        scan_addr_q <= scan_at_end ? cfg_bank_pkg::OFS_CFG_FIRST : scan_addr_q + 8'h02;
      end
    end
  end

  // host read answer
  always_ff @(posedge mclk) begin
    if (rst) begin
      host_rd_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= cfg_bank_pkg::WORD_RST;
    end else begin
      host_rd_q <= cfg_re;
      rvalid_q <= host_rd_q;
      if (host_rd_q) begin
        rdata_q <= rd;
      end
    end
  end

  // running checksums, restarted at every scan
  always_ff @(posedge mclk) begin
    if (rst) begin
      crc_c_q <= cfg_bank_pkg::CRC_INIT;
      crc_l_q <= cfg_bank_pkg::CRC_INIT;
    end else if (state_q == cfg_bank_pkg::SC_IDLE) begin
      crc_c_q <= cfg_bank_pkg::CRC_INIT;
      crc_l_q <= cfg_bank_pkg::CRC_INIT;
    end else begin
      if (in_cfg) begin
        crc_c_q <= crc_c_word;
      end else if (at_crcadr) begin
        crc_c_q <= crc_c_tail;
      end
      if (in_lut) begin
        crc_l_q <= crc_l_word;
      end else if (at_lutcrc) begin
        crc_l_q <= crc_l_tail;
      end
    end
  end

  // shadow copies caught during the scan
  always_ff @(posedge mclk) begin
    if (rst) begin
      sh_lock_q <= cfg_bank_pkg::WORD_RST;
      sh_proto_q <= cfg_bank_pkg::WORD_RST;
      sh_crcadr_q <= cfg_bank_pkg::WORD_RST;
      sh_lutcrc_q <= cfg_bank_pkg::WORD_RST;
      sh_id0_q <= cfg_bank_pkg::WORD_RST;
      sh_id1_q <= cfg_bank_pkg::WORD_RST;
    end else if (scan_rd_q) begin
      if (tag_q == cfg_bank_pkg::OFS_LOCK) sh_lock_q <= rd;
      if (tag_q == cfg_bank_pkg::OFS_PROTO) sh_proto_q <= rd;
      if (tag_q == cfg_bank_pkg::OFS_CRCADR) sh_crcadr_q <= rd;
      if (tag_q == cfg_bank_pkg::OFS_LUTCRC) sh_lutcrc_q <= rd;
      if (tag_q == cfg_bank_pkg::OFS_ID0) sh_id0_q <= rd;
      if (tag_q == cfg_bank_pkg::OFS_ID1) sh_id1_q <= rd;
    end
  end

  // working values: all change together, so no half-updated set is seen
  always_ff @(posedge mclk) begin
    if (rst) begin
      proto_q <= cfg_bank_pkg::WORD_RST;
      crcadr_q <= cfg_bank_pkg::WORD_RST;
      ut_q <= cfg_bank_pkg::UT0_CYC;
      low_q <= 10'(cfg_bank_pkg::UT0_CYC) * cfg_bank_pkg::LOW_LONG_UT;
      trig_q <= 14'(cfg_bank_pkg::UT0_CYC) * cfg_bank_pkg::TRIG_UT;
      id_q <= 32'h0000_0000;
      cfg_ok_q <= 1'b0;
      lut_ok_q <= 1'b0;
      pub_done_q <= 1'b0;
    end else begin
      pub_done_q <= pub;
      if (pub) begin
        proto_q <= eff_proto;
        crcadr_q <= sh_crcadr_q;
        ut_q <= ut_n;
        low_q <= 10'(ut_n) * low_mul;
        trig_q <= 14'(ut_n) * cfg_bank_pkg::TRIG_UT;
        id_q <= {sh_id0_q, sh_id1_q};
        cfg_ok_q <= (crc_c_q == sh_crcadr_q[cfg_bank_pkg::CA_CRC_HI:0]);
        lut_ok_q <= (crc_l_q == sh_lutcrc_q[cfg_bank_pkg::CA_CRC_HI:0]);
      end
    end
  end

  // strap pins come from outside the clock domain
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      link_addr_q <= 2'h0;
    end else begin
      pin_s1_q <= addr_pins;
      pin_s2_q <= pin_s1_q;
      link_addr_q <= crcadr_q[cfg_bank_pkg::CA_SRC] ? pin_s2_q :
                     crcadr_q[cfg_bank_pkg::CA_ID_HI:cfg_bank_pkg::CA_ID_LO];
    end
  end

  assign cfg_rdata = rdata_q;
  assign cfg_rvalid = rvalid_q;
  assign protocol_choice = proto_q[cfg_bank_pkg::PS_MODE_HI:cfg_bank_pkg::PS_MODE_LO];
  assign pwm_start_falling = proto_q[cfg_bank_pkg::PS_EDGE];
  assign low_phase_cycles = low_q;
  assign temperature_nibbles_on = proto_q[cfg_bank_pkg::PS_TEMP];
  assign counter_nibble_on = ~proto_q[cfg_bank_pkg::PS_CNT_OFF];
  assign counter_in_checksum = proto_q[cfg_bank_pkg::PS_CNT_CRC];
  assign trigger_length_variable = proto_q[cfg_bank_pkg::PS_TRIG];
  assign trigger_cycles = trig_q;
  assign frame_variant_select = proto_q[cfg_bank_pkg::PS_VARIANT];
  assign error_in_data = ~proto_q[cfg_bank_pkg::PS_ERR];
  assign error_data_code = cfg_bank_pkg::ERR_CODE;
  assign pause_pulse_on = proto_q[cfg_bank_pkg::PS_PAUSE];
  assign slow_message_on = proto_q[cfg_bank_pkg::PS_SSM];
  assign unit_time_cycles = ut_q;
  assign link_address = link_addr_q;
  assign triggered_slave_id =
    crcadr_q[cfg_bank_pkg::CA_ID_HI:cfg_bank_pkg::CA_ID_LO];
  assign cfg_crc_ok = cfg_ok_q;
  assign lut_crc_ok = lut_ok_q;
  assign slow_message_id = id_q;
  assign working_refresh = pub_done_q;

  // checking helpers
  logic [10:0] gap_q;
  logic seen_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      gap_q <= 11'h000;
      seen_q <= 1'b0;
    end else begin
      gap_q <= tick ? 11'h000 : gap_q + 11'h001;
      seen_q <= seen_q | tick;
    end
  end

  sequence s_publish;
    pub ##1 pub_done_q;
  endsequence

  sequence s_host_read;
    cfg_re ##1 host_rd_q;
  endsequence

  chk_lock_mask: assert property (@(posedge mclk) disable iff (rst)
    pub |=> (proto_q[12:0] == $past(sh_proto_q[12:0] & sh_lock_q[12:0])))
    else $error("locked protocol bit took effect");

  chk_mode_field: assert property (@(posedge mclk) disable iff (rst)
    pub |=> (protocol_choice == (PROTOCOL_SELECTABLE ?
             $past(sh_proto_q[15:13] & sh_lock_q[15:13]) : FIXED_PROTOCOL)))
    else $error("protocol choice not taken from masked field");

  chk_low_phase: assert property (@(posedge mclk) disable iff (rst)
    low_phase_cycles == 10'(unit_time_cycles) *
      (proto_q[cfg_bank_pkg::PS_LOW] ? 10'h003 : 10'h005))
    else $error("low phase length wrong");

  chk_unit_time: assert property (@(posedge mclk) disable iff (rst)
    s_publish |-> (unit_time_cycles == ut_cycles($past(eff_proto[2:0]))))
    else $error("unit time does not match code");

  chk_trigger_len: assert property (@(posedge mclk) disable iff (rst)
    trigger_cycles == 14'(unit_time_cycles) * 14'h005a)
    else $error("trigger length is not 90 unit times");

  chk_addr_source: assert property (@(posedge mclk) disable iff (rst)
    crcadr_q[10] && $stable(crcadr_q) |=> (link_address == $past(pin_s2_q)))
    else $error("link address not from pins");

  chk_stored_addr: assert property (@(posedge mclk) disable iff (rst)
    !crcadr_q[10] && $stable(crcadr_q) |=> (link_address == $past(triggered_slave_id)))
    else $error("link address not from stored field");

  chk_update_gap: assert property (@(posedge mclk) disable iff (rst)
    tick && seen_q |-> (gap_q == 11'(cfg_bank_pkg::UPDATE_CYC - 1)))
    else $error("update period wrong");

  chk_cfg_checksum: assert property (@(posedge mclk) disable iff (rst)
    pub |=> (cfg_crc_ok == ($past(crc_c_q) == $past(sh_crcadr_q[7:0]))))
    else $error("config checksum flag wrong");

  chk_lut_checksum: assert property (@(posedge mclk) disable iff (rst)
    pub |=> (lut_crc_ok == ($past(crc_l_q) == $past(sh_lutcrc_q[7:0]))))
    else $error("table checksum flag wrong");

  chk_message_id: assert property (@(posedge mclk) disable iff (rst)
    pub |=> (slow_message_id == {$past(sh_id0_q), $past(sh_id1_q)}))
    else $error("message identifier not refreshed");

  chk_host_answer: assert property (@(posedge mclk) disable iff (rst)
    s_host_read |=> (cfg_rvalid && cfg_rdata == $past(mbus.rdata)))
    else $error("host read answer late or wrong");
endmodule

/* dv/prog_tool_model.sv */
// programming tool model: word writes, word reads and checksum arithmetic
`timescale 1ns/1ps
module prog_tool_model #(
  parameter logic [7:0] POLY = 8'h1d
) (
  // clock
  input wire logic mclk,
  // word port toward the bank
  output logic cfg_we,
  output logic cfg_re,
  output logic [7:0] cfg_addr,
  output logic [15:0] cfg_wdata
);
  initial begin
    cfg_we = 1'b0;
    cfg_re = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 16'h0000;
  end

  // one word per strobe; released lines show the inverse so stale data never looks valid
  task automatic put(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    cfg_we <= w;
    cfg_re <= !w;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge mclk);
    cfg_we <= 1'b0;
    cfg_re <= 1'b0;
    cfg_addr <= ~a;
    cfg_wdata <= ~d;
  endtask

  // tool side of both checksums: msb first, top n bits of w
  function automatic logic [7:0] crc_bits(input logic [7:0] c, input logic [15:0] w,
                                          input int n);
    logic [7:0] k;
    k = c;
    for (int i = 15; i > 15 - n; i--) begin
      k = {k[6:0], 1'b0} ^ ((k[7] ^ w[i]) ? POLY : 8'h00);
    end
    return k;
  endfunction
endmodule

/* dv/output_protocol_config_bank_tb.sv */
// self-checking bench of the output protocol configuration bank
`timescale 1ns/1ps
module output_protocol_config_bank_tb;
  logic mclk;
  logic rst;
  logic [1:0] addr_pins;
  logic cfg_we, cfg_re, cfg_rvalid;
  logic [7:0] cfg_addr;
  logic [15:0] cfg_wdata, cfg_rdata;
  logic [2:0] protocol_choice;
  logic pwm_start_falling, temperature_nibbles_on, counter_nibble_on, counter_in_checksum;
  logic trigger_length_variable, frame_variant_select, error_in_data, pause_pulse_on;
  logic slow_message_on, cfg_crc_ok, lut_crc_ok, working_refresh;
  logic [9:0] low_phase_cycles;
  logic [13:0] trigger_cycles;
  logic [11:0] error_data_code;
  logic [7:0] unit_time_cycles;
  logic [1:0] link_address, triggered_slave_id;
  logic [31:0] slow_message_id;
  logic [15:0] mirror [128];
  logic [15:0] rd_q [$];
  int errors, samples_checked, seed;

  output_protocol_config_bank i_dut (
    .mclk, .rst, .cfg_we, .cfg_re, .cfg_addr, .cfg_wdata, .cfg_rdata, .cfg_rvalid, .addr_pins,
    .protocol_choice, .pwm_start_falling, .low_phase_cycles, .temperature_nibbles_on,
    .counter_nibble_on, .counter_in_checksum, .trigger_length_variable, .trigger_cycles,
    .frame_variant_select, .error_in_data, .error_data_code, .pause_pulse_on,
    .slow_message_on, .unit_time_cycles, .link_address, .triggered_slave_id, .cfg_crc_ok,
    .lut_crc_ok, .slow_message_id, .working_refresh
  );

  prog_tool_model i_tool (.mclk, .cfg_we, .cfg_re, .cfg_addr, .cfg_wdata);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_word(input logic [15:0] got);
    samples_checked++;
    if (rd_q.size() == 0 || got !== rd_q[0]) begin
      errors++;
      $display("CHECK FAILED at %0t: read data %h", $time, got);
    end
    if (rd_q.size() > 0) void'(rd_q.pop_front());
  endtask

  // read answers are matched in order against the notes left by read_word
  always @(posedge mclk) begin
    if (cfg_rvalid === 1'b1) check_word(cfg_rdata);
  end

  task automatic put_word(input logic [7:0] a, input logic [15:0] d);
    mirror[a[7:1]] = d;
    i_tool.put(1'b1, a, d);
  endtask

  task automatic read_word(input logic [7:0] a);
    rd_q.push_back(mirror[a[7:1]]);
    i_tool.put(1'b0, a, 16'h0000);
  endtask

  task automatic wait_refresh(input int n, output int k);
    repeat (n) begin
      k = 0;
      do begin
        @(posedge mclk);
        #1;
        k++;
      end while (working_refresh !== 1'b1 && k < 3000);
      if (k == 3000) begin
        check_val(32'h0, 32'h1, "no refresh");
        test_done();
      end
    end
  endtask

  task automatic check_reset();
    check_val(protocol_choice, 32'h0, "reset mode");
    check_val(unit_time_cycles, 32'h96, "reset unit time");
    check_val(low_phase_cycles, 32'h2ee, "reset low phase");
    check_val(trigger_cycles, 32'h34bc, "reset trigger");
    check_val({cfg_crc_ok, lut_crc_ok, cfg_rvalid}, 32'h0, "reset flags");
    check_val(slow_message_id, 32'h0, "reset id");
  endtask

  task automatic check_decode(input logic [15:0] p, input logic [15:0] l, input logic [15:0] c);
    logic [15:0] m;
    logic [7:0] ut;
    m = p & l;
    ut = (m[2:0] > 3'h4) ? 8'h96 : 8'h96 - 8'h19 * m[2:0];
    check_val(protocol_choice, m[15:13], "mode");
    check_val(pwm_start_falling, m[12], "start edge");
    check_val(low_phase_cycles, ut * (m[11] ? 32'h3 : 32'h5), "low phase");
    check_val(temperature_nibbles_on, m[10], "temperature");
    check_val(counter_nibble_on, !m[9], "counter nibble");
    check_val(counter_in_checksum, m[8], "counter checksum");
    check_val(trigger_length_variable, m[7], "trigger kind");
    check_val(trigger_cycles, ut * 32'h5a, "trigger length");
    check_val(frame_variant_select, m[6], "variant");
    check_val(error_in_data, !m[5], "error style");
    check_val(error_data_code, 32'hffb, "error code");
    check_val(pause_pulse_on, m[4], "pause");
    check_val(slow_message_on, m[3], "slow message");
    check_val(unit_time_cycles, ut, "unit time");
    check_val(link_address, c[10] ? addr_pins : c[9:8], "link address");
    check_val(triggered_slave_id, c[9:8], "slave id");
    check_val(slow_message_id, {mirror[7'h79], mirror[7'h7a]}, "customer id");
  endtask

  // bad[0] spoils the config checksum, bad[1] the table checksum
  task automatic apply(input logic [15:0] p, input logic [15:0] l, input logic [15:0] c,
                       input logic [1:0] bad);
    logic [7:0] k;
    logic [7:0] t;
    int n;
    mirror[7'h51] = p;
    mirror[7'h4d] = l;
    k = 8'hff;
    t = 8'hff;
    for (int i = 7'h4b; i < 7'h52; i++) k = i_tool.crc_bits(k, mirror[i], 16);
    k = i_tool.crc_bits(k, c, 8);
    for (int i = 7'h58; i < 7'h78; i++) t = i_tool.crc_bits(t, mirror[i], 16);
    t = i_tool.crc_bits(t, mirror[7'h78], 8);
    put_word(8'h9a, l);
    put_word(8'ha2, p);
    put_word(8'ha4, {c[15:8], k ^ {8{bad[0]}}});
    put_word(8'hf0, {mirror[7'h78][15:8], t ^ {8{bad[1]}}});
    // a scan may already be half done with old words, so let a full one pass
    wait_refresh(2, n);
    check_decode(p, l, c);
    check_val(cfg_crc_ok, !bad[0], "config checksum");
    check_val(lut_crc_ok, !bad[1], "table checksum");
    read_word(8'ha2);
    read_word(8'ha5);
    read_word(8'h9a);
    read_word(8'hf1);
    repeat (4) @(posedge mclk);
  endtask

  initial begin
    logic [15:0] p, l, c;
    int k;
    seed = 56;
    errors = 0;
    samples_checked = 0;
    rst = 1'b1;
    addr_pins = 2'b10;
    for (int i = 0; i < 128; i++) mirror[i] = 16'h0000;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    #1;
    check_reset();
    for (int i = 7'h4b; i < 7'h7b; i++) put_word(8'(i * 2), 16'($random(seed)));
    $display("fill done");
    l = 16'hffff;
    for (int i = 0; i < 6; i++) begin
      p = {3'h4 >> (i % 3), i[0] ? 10'h2aa : 10'h155, 3'(i)};
      c = {mirror[7'h52][15:11], 1'b1, 2'(i), 8'h00};
      apply(p, l, c, 2'(i));
    end
    $display("mode table done");
    l = 16'h1fff;
    p = 16'hffff;
    apply(p, l, c, 2'b00);
    $display("lock test done");
    // stored address source on purpose, to see the strap pins ignored
    c = {mirror[7'h52][15:11], 1'b0, 2'b01, 8'h00};
    apply(p, l, c, 2'b00);
    c[10] = 1'b1;
    apply(p, l, c, 2'b00);
    @(posedge mclk);
    addr_pins <= 2'b01;
    repeat (4) @(posedge mclk);
    #1;
    check_val(link_address, 32'h1, "pin follow");
    $display("address test done");
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    check_reset();
    @(posedge mclk);
    rst <= 1'b0;
    wait_refresh(2, k);
    check_val(k, 32'h4e2, "refresh period");
    check_decode(p, l, c);
    check_val(rd_q.size(), 32'h0, "reads left");
    $display("reset test done");
    test_done();
  end
endmodule
